// file: design/flash_seq_pkg.sv
// constants, register map and state type of the quad-line flash sequencer
package flash_seq_pkg;

	// register byte offsets on the plain register port
	localparam logic [7:0] FLASH_ADDRESS_OFS = 8'h00;
	localparam logic [7:0] INSTRUCTION_CODE_OFS = 8'h04;
	localparam logic [7:0] CONTROLLER_STATUS_OFS = 8'h08;
	localparam logic [7:0] AHB_READ_CONTROL_OFS = 8'h0C;
	localparam logic [7:0] REQUEST_SELECT_ENABLE_OFS = 8'h10;
	localparam logic [7:0] FLAG_CLEAR_OFS = 8'h14;
	localparam logic [7:0] RECEIVE_DATA_WINDOW_OFS = 8'h18;

	// reset values
	localparam logic [31:0] AHB_READ_CONTROL_RESET = 32'h0000_0403;
	localparam logic [31:0] INSTRUCTION_CODE_RESET = 32'h0000_0000;

	// field positions
	localparam int ICR_MODE_LSB = 8;
	localparam int ICR_SIZE_LSB = 16;
	localparam int ACR_SIZE_LSB = 10;
	localparam int ACR_MODE_LSB = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_FETCH = 1;
	localparam int STAT_BURST = 2;
	localparam int STAT_UNSUP = 3;
	localparam int STAT_HELD = 4;
	localparam int STAT_RECEIVE_NOT_EMPTY_FLAG = 16;
	localparam int STAT_RXCNT_LSB = 24;
	localparam int FLAG_UNSUP_CLR = 0;
	localparam int FLAG_RX_DRAIN = 16;
	localparam int ENABLE_RX_DMA = 0;

	// instruction codes
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] OP_OCTAL_WORD_READ = 8'hE3;
	localparam logic [7:0] OP_MODE_RESET = 8'hFF;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
	localparam logic [7:0] OP_SECTOR_4K = 8'h20;
	localparam logic [7:0] OP_BLOCK_32K = 8'h52;
	localparam logic [7:0] OP_BLOCK_64K = 8'hD8;
	localparam logic [7:0] OP_SECTOR_8K = 8'h40;
	localparam logic [1:0] CONT_MODE_PATTERN = 2'h2;

	// link timing, in serial clock cycles unless named otherwise
	localparam int SYS_PERIOD_NS = 50;
	localparam int SCK_PERIOD_NS = 400;
	localparam int SCK_DIV = SCK_PERIOD_NS / SYS_PERIOD_NS;
	localparam logic [2:0] PHASE_LAST = 3'(SCK_DIV - 1);
	localparam logic [2:0] PHASE_RISE = 3'(SCK_DIV / 2 - 1);
	localparam logic [4:0] PRE_CYC = 5'h06;
	localparam logic [4:0] CMD_CYC = 5'h08;
	localparam logic [4:0] QUAD_ADDR_CYC = 5'h06;
	localparam logic [4:0] SINGLE_ADDR_CYC = 5'h18;
	localparam logic [4:0] MODE_CYC = 5'h02;
	localparam logic [4:0] QUAD_DUMMY_CYC = 5'h04;
	localparam logic [4:0] FAST_DUMMY_CYC = 5'h08;
	localparam logic [4:0] MAX_READ_WORDS = 5'h10;

	typedef enum logic [2:0] {
		IDLE, PRE, CMD, ADDR, MODE, DUMMY, DATA
	} link_state_e;

endpackage

// file: design/quad_flash_ctrl.sv
// quad-line serial flash sequencer: register commands, mapped reads, erase
// Function
// R01 - quad I/O read 0xEB and octal-word read 0xE3 on 8-byte aligned address
// R02 - mapped read fetches full size; a later miss aborts the remainder
// R03 - in continuous burst the code is sent once, then address only
// R04 - burst works for register commands and mapped reads alike
// R05 - instruction 0xFF clears internal burst state whatever the flash does
// R06 - all state including burst is kept while the system sleeps
// R07 - random quad read: 34 cycles first, 26 in burst
// R08 - sequential read: each further word every eight cycles
// R09 - buffer hit answers in one cycle with no flash command
// R10 - a DMA fetch holds the mapped read port until it ends
// R11 - receive DMA enabled: request while unread receive data exists
// R12 - DMA request rises only after the first whole received word
// R13 - erase codes 0x20 0x52 0xD8 0xC7 0x60 go out as written
// R14 - 8K sector erase 0x40 is refused
// R15 - software loads the sector start address before an erase
// R16 - software sends write enable and waits for busy clear
// R17 - software waits for controller and flash busy after erase
// R18 - 0x00A040E3 selects octal-word burst read of 64 bytes
// R19 - instruction write starts it; size high half, mode second byte
// R20 - mapped read size counts words, one to sixteen
// R21 - miss outside fetch aborts command, flushes buffer, starts anew
// R22 - drain flag clears receive-not-empty and steps the window
// R23 - busy from instruction write until the link finishes it
`timescale 1ns/1ns

module quad_flash_ctrl #(
	parameter int RX_DEPTH = 15,
	parameter int BUF_WORDS = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// mapped read port
	input wire logic memReq,
	input wire logic [23:0] memAddr,
	input wire logic memDma,
	output logic memValid,
	output logic [31:0] memData,
	output logic memHeld,
	// receive dma request
	output logic rxDmaReq,
	// serial flash pins
	output logic sck,
	output logic csN,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	input wire logic [3:0] ioIn
);

	localparam int RXW = $clog2(RX_DEPTH + 1);
	localparam int RXP = $clog2(RX_DEPTH);
	localparam int BW = $clog2(BUF_WORDS + 1);
	localparam int ICR_M = flash_seq_pkg::ICR_MODE_LSB;
	localparam int ACR_M = flash_seq_pkg::ACR_MODE_LSB;
	localparam int ACR_S = flash_seq_pkg::ACR_SIZE_LSB;

	function automatic logic isQuadIo(input logic [7:0] code);
		return code == flash_seq_pkg::OP_QUAD_IO_READ ||
			code == flash_seq_pkg::OP_OCTAL_WORD_READ;
	endfunction

	function automatic logic hasAddress(input logic [7:0] code);
		return isQuadIo(code) || code == flash_seq_pkg::OP_READ ||
			code == flash_seq_pkg::OP_FAST_READ ||
			code == flash_seq_pkg::OP_PAGE_PROGRAM ||
			code == flash_seq_pkg::OP_QUAD_PROGRAM ||
			code == flash_seq_pkg::OP_SECTOR_4K ||
			code == flash_seq_pkg::OP_BLOCK_32K ||
			code == flash_seq_pkg::OP_BLOCK_64K;
	endfunction

	function automatic logic [4:0] dummyCycles(input logic [7:0] code);
		if (code == flash_seq_pkg::OP_QUAD_IO_READ)
			return flash_seq_pkg::QUAD_DUMMY_CYC;
		if (code == flash_seq_pkg::OP_FAST_READ)
			return flash_seq_pkg::FAST_DUMMY_CYC;
		return 5'h00;
	endfunction

	// size field in words, held to one..sixteen
	function automatic logic [4:0] readWords(input logic [4:0] sz);
		if (sz == 5'h00)
			return 5'h01;
		if (sz > flash_seq_pkg::MAX_READ_WORDS)
			return flash_seq_pkg::MAX_READ_WORDS;
		return sz;
	endfunction

	logic [31:0] flashAddr_r, icr_r, acr_r, regRdata_r;
	logic rxDmaEn_r, ipPend_r, unsup_r;
	logic [3:0] ioSync1_r, ioSync2_r, ioOut_r, ioOe_r;
	flash_seq_pkg::link_state_e state_r, afterPre, afterCmd, afterAddr;
	flash_seq_pkg::link_state_e afterMode, afterDummy, nxtState;
	logic [2:0] phase_r;
	logic [4:0] cnt_r, dummy_r;
	logic [31:0] shift_r, inWord_r, wordVal_r;
	logic [5:0] inBits_r;
	logic [19:0] bitsLeft_r;
	logic [7:0] curCode_r, curMode_r;
	logic [23:0] curAddr_r;
	logic curAhb_r, quad_r, skip_r, hasAddr_r, burst_r, wordStb_r, wordAhb_r;
	logic [7:0] burstCode_r;
	logic sck_r, csN_r;
	logic [31:0] buf_r [BUF_WORDS];
	logic [21:0] bufBase_r, pendAddr_r, reqWord, diff;
	logic [BW-1:0] bufCount_r;
	logic [4:0] fetchWords_r;
	logic fetchActive_r, fetchPend_r, fetchDma_r, pend_r, pendDma_r;
	logic memValid_r, memHeld_r, rxDmaReq_r;
	logic [31:0] memData_r;
	logic [31:0] rxMem_r [RX_DEPTH];
	logic [RXP-1:0] rxWr_r, rxRd_r;
	logic [RXW-1:0] rxCount_r;
	logic tick, stall, busy, takeAhb, reqLive, reqDma, blocked, hit, covered;
	logic serve, startNew, drain, rxPush, rxPop, rxFull;
	logic [3:0] lineBits;
	logic [5:0] step;

	////////////////////////////////////////////////////////////////////////
	// pin input synchroniser, second stage is the only reader of the first
	always_ff @(posedge clk_sys) begin
		ioSync1_r <= ioIn;
		ioSync2_r <= ioSync1_r;
	end

	////////////////////////////////////////////////////////////////////////
	// register writes and instruction launch
	assign busy = ipPend_r || (state_r != flash_seq_pkg::IDLE && !curAhb_r);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flashAddr_r <= 32'h0000_0000;
			icr_r <= flash_seq_pkg::INSTRUCTION_CODE_RESET;
			acr_r <= flash_seq_pkg::AHB_READ_CONTROL_RESET;
			rxDmaEn_r <= 1'b0;
			ipPend_r <= 1'b0;
			unsup_r <= 1'b0;
		end else begin
			if (state_r == flash_seq_pkg::IDLE && ipPend_r)
				ipPend_r <= 1'b0; // taken by the link
			if (regWr && regAddr == flash_seq_pkg::FLASH_ADDRESS_OFS)
				flashAddr_r <= regWdata;
			if (regWr && regAddr == flash_seq_pkg::AHB_READ_CONTROL_OFS)
				acr_r <= regWdata; // R18 R20
			if (regWr && regAddr == flash_seq_pkg::REQUEST_SELECT_ENABLE_OFS)
				rxDmaEn_r <= regWdata[flash_seq_pkg::ENABLE_RX_DMA];
			if (regWr && regAddr == flash_seq_pkg::FLAG_CLEAR_OFS &&
					regWdata[flash_seq_pkg::FLAG_UNSUP_CLR])
				unsup_r <= 1'b0;
			if (regWr && regAddr == flash_seq_pkg::INSTRUCTION_CODE_OFS) begin
				if (regWdata[7:0] == flash_seq_pkg::OP_SECTOR_8K)
					unsup_r <= 1'b1; // R14
				else if (!busy) begin
					icr_r <= regWdata; // R13 R19
					ipPend_r <= 1'b1; // R23
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link sequencing: order of phases after the current one
	assign tick = phase_r == flash_seq_pkg::PHASE_LAST;
	assign rxFull = (rxCount_r + RXW'(wordStb_r && !wordAhb_r)) >=
		RXW'(RX_DEPTH);
	assign stall = state_r == flash_seq_pkg::DATA && !curAhb_r && rxFull &&
		phase_r == 3'h0;
	assign takeAhb = state_r == flash_seq_pkg::IDLE && !ipPend_r &&
		fetchPend_r && !startNew;
	assign step = quad_r ? 6'h04 : 6'h01;
	assign lineBits = quad_r ? ioSync2_r : {3'h0, ioSync2_r[1]};

	always_comb begin
		afterDummy = (bitsLeft_r != 20'h0) ? flash_seq_pkg::DATA :
			flash_seq_pkg::IDLE;
		afterMode = (dummy_r != 5'h00) ? flash_seq_pkg::DUMMY : afterDummy;
		afterAddr = quad_r ? flash_seq_pkg::MODE : afterMode;
		afterCmd = hasAddr_r ? flash_seq_pkg::ADDR : afterAddr;
		afterPre = skip_r ? afterCmd : flash_seq_pkg::CMD; // R03 R04
		unique case (state_r)
			flash_seq_pkg::PRE: nxtState = afterPre;
			flash_seq_pkg::CMD: nxtState = afterCmd;
			flash_seq_pkg::ADDR: nxtState = afterAddr;
			flash_seq_pkg::MODE: nxtState = afterMode;
			flash_seq_pkg::DUMMY: nxtState = afterDummy;
			default: nxtState = flash_seq_pkg::IDLE;
		endcase
	end

	// link state machine, one serial cycle per SCK_DIV system cycles
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= flash_seq_pkg::IDLE;
			phase_r <= 3'h0;
			cnt_r <= 5'h00;
			dummy_r <= 5'h00;
			shift_r <= 32'h0;
			inWord_r <= 32'h0;
			inBits_r <= 6'h00;
			bitsLeft_r <= 20'h0;
			curCode_r <= 8'h00;
			curMode_r <= 8'h00;
			curAddr_r <= 24'h0;
			curAhb_r <= 1'b0;
			quad_r <= 1'b0;
			skip_r <= 1'b0;
			hasAddr_r <= 1'b0;
			burst_r <= 1'b0;
			burstCode_r <= 8'h00;
			wordStb_r <= 1'b0;
			wordAhb_r <= 1'b0;
			wordVal_r <= 32'h0;
		end else begin
			wordStb_r <= 1'b0;
			if (state_r == flash_seq_pkg::IDLE) begin
				phase_r <= 3'h0;
				if (ipPend_r || takeAhb) begin
					curCode_r <= ipPend_r ? icr_r[7:0] : acr_r[7:0];
					curMode_r <= ipPend_r ? icr_r[ICR_M +: 8] :
						acr_r[ACR_M +: 8];
					curAddr_r <= ipPend_r ? flashAddr_r[23:0] :
						{bufBase_r, 2'h0};
					bitsLeft_r <= ipPend_r ? {1'b0, icr_r[31:16], 3'h0} :
						{10'h0, fetchWords_r, 5'h00}; // R02 R19
					curAhb_r <= !ipPend_r;
					quad_r <= isQuadIo(ipPend_r ? icr_r[7:0] : acr_r[7:0]);
					hasAddr_r <= hasAddress(ipPend_r ? icr_r[7:0] :
						acr_r[7:0]);
					dummy_r <= dummyCycles(ipPend_r ? icr_r[7:0] :
						acr_r[7:0]);
					skip_r <= burst_r && burstCode_r ==
						(ipPend_r ? icr_r[7:0] : acr_r[7:0]); // R03 R04
					if (ipPend_r && icr_r[7:0] == flash_seq_pkg::OP_MODE_RESET)
						burst_r <= 1'b0; // R05
					inBits_r <= 6'h00;
					cnt_r <= flash_seq_pkg::PRE_CYC - 5'h01; // R07
					state_r <= flash_seq_pkg::PRE;
				end
			end else if (startNew && curAhb_r) begin
				state_r <= flash_seq_pkg::IDLE; // R02 R21
			end else if (!stall) begin
				phase_r <= tick ? 3'h0 : phase_r + 3'h1;
				if (tick && state_r == flash_seq_pkg::DATA) begin
					inWord_r <= (inWord_r << step) | {28'h0, lineBits};
					bitsLeft_r <= bitsLeft_r - 20'(step);
					inBits_r <= inBits_r + step;
					if (inBits_r + step == 6'h20 || bitsLeft_r == 20'(step)) begin
						wordStb_r <= 1'b1; // R08 R12
						wordAhb_r <= curAhb_r;
						wordVal_r <= (inWord_r << step) | {28'h0, lineBits};
						inBits_r <= 6'h00;
					end
					if (bitsLeft_r == 20'(step))
						state_r <= flash_seq_pkg::IDLE;
				end else if (tick && cnt_r != 5'h00) begin
					cnt_r <= cnt_r - 5'h01;
					shift_r <= shift_r << step;
				end else if (tick) begin
					if (state_r == flash_seq_pkg::MODE) begin
						burst_r <= curMode_r[5:4] ==
							flash_seq_pkg::CONT_MODE_PATTERN; // R03 R06
						burstCode_r <= curCode_r;
					end
					state_r <= nxtState;
					unique case (nxtState)
						flash_seq_pkg::CMD: begin
							cnt_r <= flash_seq_pkg::CMD_CYC - 5'h01;
							shift_r <= {curCode_r, 24'h0};
						end
						flash_seq_pkg::ADDR: begin
							cnt_r <= (quad_r ? flash_seq_pkg::QUAD_ADDR_CYC :
								flash_seq_pkg::SINGLE_ADDR_CYC) - 5'h01;
							shift_r <= {curAddr_r[23:3], (curCode_r ==
								flash_seq_pkg::OP_OCTAL_WORD_READ) ? 3'h0 :
								curAddr_r[2:0], 8'h00}; // R01
						end
						flash_seq_pkg::MODE: begin
							cnt_r <= flash_seq_pkg::MODE_CYC - 5'h01;
							shift_r <= {curMode_r, 24'h0};
						end
						flash_seq_pkg::DUMMY: cnt_r <= dummy_r - 5'h01;
						default: cnt_r <= 5'h00;
					endcase
				end
			end
		end
	end

	// pins: clock high in the second half, data driven while sck is low
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sck_r <= 1'b0;
			csN_r <= 1'b1;
			ioOut_r <= 4'h0;
			ioOe_r <= 4'h0;
		end else begin
			csN_r <= state_r == flash_seq_pkg::IDLE;
			sck_r <= state_r != flash_seq_pkg::IDLE &&
				state_r != flash_seq_pkg::PRE && !stall &&
				phase_r >= flash_seq_pkg::PHASE_RISE &&
				phase_r != flash_seq_pkg::PHASE_LAST;
			if (state_r == flash_seq_pkg::IDLE) begin
				ioOut_r <= 4'h0;
				ioOe_r <= 4'h0;
			end else if (quad_r && (state_r == flash_seq_pkg::ADDR ||
					state_r == flash_seq_pkg::MODE)) begin
				ioOut_r <= shift_r[31:28];
				ioOe_r <= 4'hF;
			end else if (quad_r && (state_r == flash_seq_pkg::DUMMY ||
					state_r == flash_seq_pkg::DATA)) begin
				ioOut_r <= 4'h0;
				ioOe_r <= 4'h0;
			end else begin
				ioOut_r <= {3'h6, state_r == flash_seq_pkg::CMD ||
					state_r == flash_seq_pkg::ADDR ? shift_r[31] : 1'b0};
				ioOe_r <= 4'hD; // io1 listens, io2 io3 held high
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mapped read port and prefetch buffer
	assign reqLive = memReq || pend_r;
	assign reqWord = memReq ? memAddr[23:2] : pendAddr_r;
	assign reqDma = memReq ? memDma : pendDma_r;
	assign diff = reqWord - bufBase_r;
	assign hit = diff < 22'(bufCount_r);
	assign covered = fetchActive_r && diff < 22'(fetchWords_r);
	assign blocked = fetchActive_r && fetchDma_r && !reqDma; // R10
	assign serve = reqLive && !blocked && hit; // R09
	assign startNew = reqLive && !blocked && !hit && !covered; // R21

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bufBase_r <= 22'h0;
			bufCount_r <= '0;
			fetchWords_r <= 5'h01;
			fetchActive_r <= 1'b0;
			fetchPend_r <= 1'b0;
			fetchDma_r <= 1'b0;
			pend_r <= 1'b0;
			pendDma_r <= 1'b0;
			pendAddr_r <= 22'h0;
			memValid_r <= 1'b0;
			memData_r <= 32'h0;
			memHeld_r <= 1'b0;
		end else begin
			memValid_r <= serve;
			if (serve)
				memData_r <= buf_r[diff[BW-2:0]];
			if (memReq) begin
				pendAddr_r <= memAddr[23:2];
				pendDma_r <= memDma;
			end
			pend_r <= reqLive && !serve;
			if (takeAhb)
				fetchPend_r <= 1'b0;
			if (startNew) begin
				bufBase_r <= {reqWord[21:1], (acr_r[7:0] ==
					flash_seq_pkg::OP_OCTAL_WORD_READ) ? 1'b0 : reqWord[0]};
				bufCount_r <= '0; // flush
				// aligned-down octal fetch takes one more word to reach the asked one
				fetchWords_r <= readWords(acr_r[ACR_S +: 5] + 5'(acr_r[7:0] ==
					flash_seq_pkg::OP_OCTAL_WORD_READ && reqWord[0])); // R01 R20
				fetchActive_r <= 1'b1;
				fetchPend_r <= 1'b1;
				fetchDma_r <= reqDma;
			end else if (wordStb_r && wordAhb_r && fetchActive_r) begin
				buf_r[bufCount_r[BW-2:0]] <= wordVal_r;
				bufCount_r <= bufCount_r + BW'(1);
				if (bufCount_r + BW'(1) == BW'(fetchWords_r))
					fetchActive_r <= 1'b0;
			end
			memHeld_r <= fetchActive_r && fetchDma_r; // R10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive buffer for register-issued reads and dma request
	assign drain = regWr && regAddr == flash_seq_pkg::FLAG_CLEAR_OFS &&
		regWdata[flash_seq_pkg::FLAG_RX_DRAIN];
	assign rxPush = wordStb_r && !wordAhb_r;
	assign rxPop = drain && rxCount_r != '0; // R22

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rxWr_r <= '0;
			rxRd_r <= '0;
			rxCount_r <= '0;
			rxDmaReq_r <= 1'b0;
		end else begin
			if (rxPush) begin
				rxMem_r[rxWr_r] <= wordVal_r;
				rxWr_r <= (rxWr_r == RXP'(RX_DEPTH - 1)) ? '0 : rxWr_r + RXP'(1);
			end
			if (rxPop)
				rxRd_r <= (rxRd_r == RXP'(RX_DEPTH - 1)) ? '0 : rxRd_r + RXP'(1);
			rxCount_r <= rxCount_r + RXW'(rxPush) - RXW'(rxPop);
			rxDmaReq_r <= rxDmaEn_r && (rxCount_r + RXW'(rxPush) -
				RXW'(rxPop)) != '0; // R11 R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read data, one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset)
			regRdata_r <= 32'h0;
		else if (regRd) begin
			regRdata_r <= 32'h0;
			unique case (regAddr)
				flash_seq_pkg::FLASH_ADDRESS_OFS: regRdata_r <= flashAddr_r;
				flash_seq_pkg::INSTRUCTION_CODE_OFS: regRdata_r <= icr_r;
				flash_seq_pkg::AHB_READ_CONTROL_OFS: regRdata_r <= acr_r;
				flash_seq_pkg::REQUEST_SELECT_ENABLE_OFS:
					regRdata_r <= {31'h0, rxDmaEn_r};
				flash_seq_pkg::RECEIVE_DATA_WINDOW_OFS:
					regRdata_r <= (rxCount_r != '0) ? rxMem_r[rxRd_r] : 32'h0;
				flash_seq_pkg::CONTROLLER_STATUS_OFS: begin
					regRdata_r[flash_seq_pkg::STAT_BUSY] <= busy; // R23
					regRdata_r[flash_seq_pkg::STAT_FETCH] <= fetchActive_r;
					regRdata_r[flash_seq_pkg::STAT_BURST] <= burst_r;
					regRdata_r[flash_seq_pkg::STAT_UNSUP] <= unsup_r;
					regRdata_r[flash_seq_pkg::STAT_HELD] <= memHeld_r;
					regRdata_r[flash_seq_pkg::STAT_RECEIVE_NOT_EMPTY_FLAG] <= rxCount_r != '0;
					regRdata_r[flash_seq_pkg::STAT_RXCNT_LSB +: 4] <=
						4'(rxCount_r);
				end
				default: regRdata_r <= 32'h0;
			endcase
		end
	end

	// outputs straight from flip-flops
	assign regRdata = regRdata_r;
	assign memValid = memValid_r;
	assign memData = memData_r;
	assign memHeld = memHeld_r;
	assign rxDmaReq = rxDmaReq_r;
	assign sck = sck_r;
	assign csN = csN_r;
	assign ioOut = ioOut_r;
	assign ioOe = ioOe_r;

endmodule

// file: tb/flash_seq_monitor.sv
// port checker for the quad-line flash sequencer
`timescale 1ns/1ns
module flash_seq_checker #(
	parameter int RX_DEPTH = 15,
	parameter int BUF_WORDS = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register and mapped read ports
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic memReq,
	input wire logic memDma,
	input wire logic memValid,
	input wire logic rxDmaReq,
	// serial pins
	input wire logic sck,
	input wire logic csN,
	input wire logic [3:0] ioOe
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	logic reqPend_r;
	logic dmaEn_r;

	// open mapped request and shadow of the receive dma enable
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reqPend_r <= 1'b0;
			dmaEn_r <= 1'b0;
		end else begin
			if (memReq) begin
				reqPend_r <= 1'b1;
			end else if (memValid) begin
				reqPend_r <= 1'b0;
			end
			if (regWr &&
				regAddr == flash_seq_pkg::REQUEST_SELECT_ENABLE_OFS) begin
				dmaEn_r <= regWdata[flash_seq_pkg::ENABLE_RX_DMA];
			end
		end
	end

	chk_reset_quiet: assert property (disable iff (1'b0)
		reset |=> csN && !sck && ioOe == 4'h0 && !memValid && !rxDmaReq)
		else $error("outputs not quiet after reset");
	chk_idle_lines: assert property (csN [*2] |-> !sck && ioOe == 4'h0)
		else $error("serial lines active while deselected");
	// an abort cuts the pulse and raises select, so only whole pulses count
	chk_sck_high: assert property ($rose(sck) ##1 !csN [*4] |->
		$past(sck, 3) && $past(sck, 2) && $past(sck) && !sck)
		else $error("serial clock high phase not four cycles");
	chk_pre_gap: assert property ($fell(csN) |-> !sck [*8])
		else $error("serial clock too soon after select");
	chk_valid_pulse: assert property (memValid |=> !memValid)
		else $error("answer pulse longer than one cycle");
	chk_valid_cause: assert property (memValid |-> reqPend_r)
		else $error("answer without a request");
	chk_dma_drain: assert property ($fell(rxDmaReq) |->
		$past(regWr) || $past(regWr, 2) || $past(regWr, 3))
		else $error("dma request dropped without a register write");
	chk_dma_enable: assert property (
		!dmaEn_r && !$past(dmaEn_r) |-> !rxDmaReq)
		else $error("dma request while disabled");

	cover property (memValid && memDma);
	cover property ($rose(rxDmaReq));
	cover property ($fell(csN));
endmodule

bind quad_flash_ctrl flash_seq_checker #(
	.RX_DEPTH(RX_DEPTH),
	.BUF_WORDS(BUF_WORDS)
) chkInst (
	.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .memReq(memReq),
	.memDma(memDma), .memValid(memValid), .rxDmaReq(rxDmaReq),
	.sck(sck), .csN(csN), .ioOe(ioOe)
);

// file: tb/serial_flash_model.sv
// behavioural quad-line serial flash on the far side of the sequencer
`timescale 1ns/1ns
module serial_flash_model (
	// serial pins from the sequencer
	input wire logic sck,
	input wire logic csN,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOe,
	// resolved line levels and observation
	output logic [3:0] ioIn,
	output logic [7:0] lastCmd,
	output int frames
);
	logic [3:0] drv = 4'h0;
	logic [7:0] cmd = 8'h00;
	int falls = 0;
	int rises = 0;
	initial frames = 0;
	initial lastCmd = 8'h00;

	// frame start clears the bit counters
	always @(negedge csN) begin
		falls = 0;
		rises = 0;
		frames = frames + 1;
	end
	// first byte on io0 is taken as the code; mode codes are ignored
	always @(posedge sck) begin
		if (!csN && rises < 8) begin
			cmd = {cmd[6:0], ioIn[0]};
			rises = rises + 1;
			if (rises == 8) lastCmd = cmd;
		end
	end
	// data shifted out on the falling edge, pattern set by bit count
	always @(negedge sck) begin
		if (!csN) begin
			falls = falls + 1;
			drv = 4'(falls);
		end
	end
	// released lines show the inverse of the last value
	always @(posedge csN) drv = ~drv;
	// wire level: the driving party wins
	assign ioIn = (ioOe & ioOut) | (~ioOe & drv);
endmodule

// file: tb/tb.sv
// self-checking bench: registers, mapped reads, erase and receive dma
`timescale 1ns/1ns
module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic memReq = 1'b0;
	logic [23:0] memAddr = 24'h0;
	logic memDma = 1'b0;
	logic [31:0] regRdata, memData;
	logic memValid, memHeld, rxDmaReq, sck, csN;
	logic [3:0] ioOut, ioOe, ioIn;
	logic [7:0] lastCmd;
	logic rdPend = 1'b0;
	logic dmaSel;
	logic [31:0] expQ[$], mskQ[$], memQ[$];
	logic [23:0] base;
	logic [7:0] codes[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
	int frames, lat, f;
	int err_count = 0;
	int check_count = 0;
	int seed = 32'h1D1D;

	quad_flash_ctrl quad_flash_ctrl_inst (.clk_sys(clk_sys), .reset(reset),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .memReq(memReq), .memAddr(memAddr),
		.memDma(memDma), .memValid(memValid), .memData(memData),
		.memHeld(memHeld), .rxDmaReq(rxDmaReq), .sck(sck), .csN(csN),
		.ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn));
	serial_flash_model serial_flash_model_inst (.sck(sck), .csN(csN),
		.ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .lastCmd(lastCmd),
		.frames(frames));

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
	endtask
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rd(flash_seq_pkg::CONTROLLER_STATUS_OFS, e, m);
	endtask
	task automatic ic(input logic [31:0] d);
		wr(flash_seq_pkg::INSTRUCTION_CODE_OFS, d);
	endtask
	// mapped read; lat counts cycles from request to answer
	task automatic mrd(input logic [23:0] a, input logic [31:0] e);
		memQ.push_back(e);
		@(posedge clk_sys);
		memReq <= 1'b1;
		memAddr <= a;
		memDma <= dmaSel;
		@(posedge clk_sys);
		memReq <= 1'b0;
		lat = 1;
		while (memValid !== 1'b1 && lat < 2000) begin
			@(posedge clk_sys);
			lat++;
		end
		lat = lat - 1;
	endtask
	task automatic inLat(input string nm, input int lo, input int hi);
		chk(nm, 32'h1, 32'(lat >= lo && lat <= hi));
	endtask
	// wait for a quiet link, bounded
	task automatic waitIdle();
		int q;
		q = 0;
		lat = 0;
		while (q < 24 && lat < 20000) begin
			@(posedge clk_sys);
			lat++;
			q = csN === 1'b1 ? q + 1 : 0;
		end
		inLat("linkIdle", 0, 19999);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// answer watcher: oldest note against each result
	always @(posedge clk_sys) begin
		rdPend <= regRd;
		if (rdPend) chk("regRdata", expQ.pop_front(), regRdata & mskQ.pop_front());
		if (memValid === 1'b1) chk("memData", memQ.pop_front(), memData);
	end
	// main sequence
	initial begin
		dmaSel = 1'($random(seed));
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		rd(flash_seq_pkg::AHB_READ_CONTROL_OFS,
			flash_seq_pkg::AHB_READ_CONTROL_RESET, '1);
		wr(flash_seq_pkg::AHB_READ_CONTROL_OFS, 32'h00A040E3);
		rd(flash_seq_pkg::AHB_READ_CONTROL_OFS, 32'h00A040E3, '1);
		rd(8'h1C, 32'h0, '1);
		wr(flash_seq_pkg::AHB_READ_CONTROL_OFS, 32'h00A004EB);
		base = 24'($random(seed)) & 24'h3FFFC0;
		mrd(base, 32'h456789AB);
		inLat("firstLat", 272, 290);
		mrd(base ^ 24'h400000, 32'hCDEF0123);
		inLat("burstLat", 208, 226);
		st(32'h4, 32'h4);
		wr(flash_seq_pkg::AHB_READ_CONTROL_OFS, 32'h00A040EB);
		base = base ^ 24'h800000;
		mrd(base, 32'hCDEF0123);
		mrd(base + 24'h4, 32'h456789AB);
		inLat("seqLat", 56, 66);
		chk("memHeld", 32'(dmaSel), 32'(memHeld));
		base = base ^ 24'h200000;
		mrd(base, 32'hCDEF0123);
		inLat("abortLat", 208, 250);
		waitIdle();
		f = frames;
		mrd(base + 24'h3C, 32'h456789AB);
		inLat("hitLat", 1, 1);
		mrd(base, 32'hCDEF0123);
		chk("hitFrames", 32'(f), 32'(frames));
		wr(flash_seq_pkg::AHB_READ_CONTROL_OFS, 32'h00A004E3);
		mrd(base ^ 24'h100004, 32'h89ABCDEF);
		ic(32'hFF);
		waitIdle();
		chk("modeReset", 32'hFF, 32'(lastCmd));
		st(32'h0, 32'h4);
		foreach (codes[i]) begin
			ic(32'h06);
			waitIdle();
			chk("writeEnable", 32'h06, 32'(lastCmd));
			wr(flash_seq_pkg::FLASH_ADDRESS_OFS, $random(seed) & 32'hFFF000);
			ic(32'(codes[i]));
			st(32'h1, 32'h1);
			waitIdle();
			chk("eraseCode", 32'(codes[i]), 32'(lastCmd));
			st(32'h0, 32'h1);
		end
		f = frames;
		ic(32'h40);
		waitIdle();
		chk("refusedFrames", 32'(f), 32'(frames));
		st(32'h8, 32'h8);
		wr(flash_seq_pkg::FLAG_CLEAR_OFS, 32'h1);
		st(32'h0, 32'h8);
		wr(flash_seq_pkg::REQUEST_SELECT_ENABLE_OFS, 32'h1);
		ic(32'h0008_0003);
		lat = 0;
		while (rxDmaReq !== 1'b1 && lat < 2000) begin
			@(posedge clk_sys);
			lat++;
		end
		inLat("dmaFirstWord", 556, 585);
		rd(flash_seq_pkg::RECEIVE_DATA_WINDOW_OFS, 32'h33333333, '1);
		wr(flash_seq_pkg::FLAG_CLEAR_OFS, 32'h10000);
		waitIdle();
		chk("dmaSecond", 32'h1, 32'(rxDmaReq));
		rd(flash_seq_pkg::RECEIVE_DATA_WINDOW_OFS, 32'h33333333, '1);
		wr(flash_seq_pkg::FLAG_CLEAR_OFS, 32'h10000);
		repeat (4) @(posedge clk_sys);
		chk("dmaDrained", 32'h0, 32'(rxDmaReq));
		st(32'h0, 32'h10000);
		repeat (4) @(posedge clk_sys);
		test_done();
	end
	// watchdog against a hang
	initial begin
		#2000000;
		err_count++;
		test_done();
	end
endmodule
